// >>> hw/ese_div.sv
// sequential unsigned restoring divider for the speed scaling
`timescale 1ns/1ns
module ese_div #(
	parameter int unsigned WN = 42,
	parameter int unsigned WD = 31
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// request
	input wire logic start_i,
	input wire logic [WN-1:0] dividend_i,
	input wire logic [WD-1:0] divisor_i,
	// answer
	output logic busy_o,
	output logic done_o,
	output logic [WN-1:0] quot_o
);
	localparam int unsigned CW = $clog2(WN + 1);

	logic [WD:0] rem_r, rem_nxt;
	logic [WN-1:0] quot_r, quot_nxt;
	logic [WD-1:0] dvs_r, dvs_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic busy_r, busy_nxt, done_r, done_nxt;
	logic [WD:0] trial;

	// one quotient bit per cycle, WN cycles per division
	always_comb begin
		rem_nxt = rem_r;
		quot_nxt = quot_r;
		dvs_nxt = dvs_r;
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		trial = {rem_r[WD-1:0], quot_r[WN-1]};
		if (start_i && !busy_r) begin
			rem_nxt = '0;
			quot_nxt = dividend_i;
			dvs_nxt = divisor_i;
			cnt_nxt = CW'(WN);
			busy_nxt = 1'b1;
		end else if (busy_r) begin
			quot_nxt = {quot_r[WN-2:0], 1'b0};
			if (trial >= {1'b0, dvs_r}) begin
				rem_nxt = trial - {1'b0, dvs_r};
				quot_nxt[0] = 1'b1;
			end else begin
				rem_nxt = trial;
			end
			cnt_nxt = cnt_r - 1'b1;
			if (cnt_r == CW'(1)) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rem_r <= '0;
			quot_r <= '0;
			dvs_r <= '0;
			cnt_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			rem_r <= rem_nxt;
			quot_r <= quot_nxt;
			dvs_r <= dvs_nxt;
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign busy_o = busy_r;
	assign done_o = done_r;
	assign quot_o = quot_r;
endmodule

// >>> hw/ese_top.sv
// encoder edge evaluation, reference check, speed scaling and monitoring values
`timescale 1ns/1ns
module ese_top
	import ese_pkg::*;
#(
	parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// encoder tracks
	input wire logic track_a_i,
	input wire logic track_b_i,
	input wire logic track_z_i,
	// settings and process values
	input wire ese_cfg_s cfg_i,
	input wire ese_proc_s proc_i,
	input wire logic fault_clr_i,
	// encoder results
	output logic signed [31:0] position_o,
	output logic dir_cw_o,
	output logic signed [31:0] speed_rpm_o,
	output logic speed_valid_o,
	output logic ref_fault_o,
	output logic ref_fault_flag_o,
	// monitoring values
	output logic signed [33:0] sys_value_o,
	output logic [17:0] flow_o,
	output logic [15:0] pressure_o
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// smallest k with SAMPLE_US * 2^k >= tc: filter gain 2^-k
	function automatic logic [2:0] filt_shift(input logic [14:0] tc);
		logic [2:0] k;
		k = 3'(FILT_SH_MAX);
		for (int i = FILT_SH_MAX - 1; i >= 0; i--) begin
			if ((32'(SAMPLE_US) << i) >= 32'(tc)) begin
				k = 3'(i);
			end
		end
		return k;
	endfunction

	// resolution multiplier as a shift: 1, 2 or 4 counts per mark
	function automatic logic [1:0] eval_shift(input ese_eval_e m);
		logic [1:0] s;
		unique case (m)
			ESE_EVAL_SINGLE: s = 2'h0;
			ESE_EVAL_DOUBLE: s = 2'h1;
			default: s = 2'h2;
		endcase
		return s;
	endfunction

	// ----------------------------------------------------------------
	// setting clamps
	// ----------------------------------------------------------------
	logic signed [15:0] num_c;
	logic [14:0] den_c, tc_c;
	logic [13:0] marks_c;
	logic [1:0] esh;
	logic [15:0] marks_eff;

	always_comb begin
		num_c = $signed(cfg_i.gear_num);
		if (num_c > GEAR_NUM_MAX) num_c = GEAR_NUM_MAX;
		if (num_c < GEAR_NUM_MIN) num_c = GEAR_NUM_MIN;
		den_c = cfg_i.gear_den;
		if (den_c < GEAR_DEN_MIN) den_c = GEAR_DEN_MIN;
		if (den_c > GEAR_DEN_MAX) den_c = GEAR_DEN_MAX;
		tc_c = (cfg_i.filt_tc > FILT_TC_MAX) ? FILT_TC_MAX : cfg_i.filt_tc;
		marks_c = cfg_i.marks;
		if (marks_c < MARKS_MIN) marks_c = MARKS_MIN;
		if (marks_c > MARKS_MAX) marks_c = MARKS_MAX;
		esh = eval_shift(cfg_i.eval);
		marks_eff = 16'(marks_c) << esh;
	end

	// ----------------------------------------------------------------
	// edge evaluation
	// ----------------------------------------------------------------
	logic a_q, b_q, z_q;
	logic signed [1:0] step;

	// A rise with B low is clockwise, so B lagging A counts up
	always_comb begin
		step = 2'sd0;
		unique case (cfg_i.eval)
			ESE_EVAL_SINGLE: begin
				if (track_a_i && !a_q) step = track_b_i ? -2'sd1 : 2'sd1;
			end
			ESE_EVAL_DOUBLE: begin
				if (track_a_i != a_q) begin
					step = (track_a_i ^ track_b_i) ? 2'sd1 : -2'sd1;
				end
			end
			default: begin
				unique case ({a_q, b_q, track_a_i, track_b_i})
					4'h2, 4'hB, 4'hD, 4'h4: step = 2'sd1;
					4'h8, 4'hE, 4'h7, 4'h1: step = -2'sd1;
					default: step = 2'sd0;
				endcase
			end
		endcase
		if (cfg_i.invert) step = -step;
	end

	// ----------------------------------------------------------------
	// position, direction, window count and reference check
	// ----------------------------------------------------------------
	logic signed [31:0] pos_r, pos_nxt;
	logic dir_r, dir_nxt;
	logic signed [11:0] win_r, win_nxt;
	logic [15:0] tick_r, tick_nxt;
	logic tick;
	logic [15:0] refc_r, refc_nxt;
	logic armed_r, armed_nxt, fpulse_r, fpulse_nxt, fflag_r, fflag_nxt;
	logic signed [11:0] latched;

	assign tick = (tick_r == 16'(SAMPLE_CYCLES - 1));

	always_comb begin
		pos_nxt = pos_r + 32'(step);
		dir_nxt = (step == 2'sd0) ? dir_r : (step == 2'sd1);
		tick_nxt = tick ? 16'h0000 : tick_r + 16'h0001;
		latched = win_r + 12'(step);
		win_nxt = tick ? 12'sh000 : latched;
		refc_nxt = (refc_r == 16'hFFFF || step == 2'sd0) ? refc_r : refc_r + 16'h0001;
		armed_nxt = armed_r;
		fpulse_nxt = 1'b0;
		if (!cfg_i.ref_en) begin
			armed_nxt = 1'b0;
			refc_nxt = 16'h0000;
		end else if (track_z_i && !z_q) begin
			// first pulse after enabling only arms the check
			if (armed_r && refc_nxt != marks_eff) fpulse_nxt = 1'b1;
			armed_nxt = 1'b1;
			refc_nxt = 16'h0000;
		end
		// a new fault beats a clear in the same cycle
		fflag_nxt = fpulse_nxt | (fflag_r & ~fault_clr_i);
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
			z_q <= 1'b0;
			pos_r <= '0;
			dir_r <= 1'b1;
			win_r <= '0;
			tick_r <= '0;
			refc_r <= '0;
			armed_r <= 1'b0;
			fpulse_r <= 1'b0;
			fflag_r <= 1'b0;
		end else begin
			a_q <= track_a_i;
			b_q <= track_b_i;
			z_q <= track_z_i;
			pos_r <= pos_nxt;
			dir_r <= dir_nxt;
			win_r <= win_nxt;
			tick_r <= tick_nxt;
			refc_r <= refc_nxt;
			armed_r <= armed_nxt;
			fpulse_r <= fpulse_nxt;
			fflag_r <= fflag_nxt;
		end
	end

	// ----------------------------------------------------------------
	// speed scaling and filter
	// ----------------------------------------------------------------
	// rpm = counts * RPM_K * num / (den * marks * mult); 0.01 units cancel
	ese_spd_e st_r, st_nxt;
	logic neg_r, neg_nxt;
	logic signed [31:0] raw_r, raw_nxt, filt_r, filt_nxt;
	logic vld_r, vld_nxt;
	logic [41:0] dvd;
	logic [30:0] dvs;
	logic [41:0] quot;
	logic div_start, div_done;
	logic [10:0] cnt_mag;
	logic [14:0] num_mag;
	logic signed [32:0] diff;
	logic [2:0] fsh;

	always_comb begin
		cnt_mag = latched[11] ? 11'(-latched) : 11'(latched);
		num_mag = num_c[15] ? 15'(-num_c) : 15'(num_c);
		dvd = 42'(cnt_mag) * 42'(RPM_K) * 42'(num_mag);
		dvs = 31'(den_c) * 31'(marks_eff);
		div_start = (st_r == ESE_SPD_IDLE) && tick;
		st_nxt = st_r;
		neg_nxt = neg_r;
		raw_nxt = raw_r;
		filt_nxt = filt_r;
		vld_nxt = 1'b0;
		fsh = filt_shift(tc_c);
		diff = 33'(raw_r) - 33'(filt_r);
		unique case (st_r)
			ESE_SPD_IDLE: begin
				if (tick) begin
					neg_nxt = latched[11] ^ num_c[15];
					st_nxt = ESE_SPD_DIV;
				end
			end
			ESE_SPD_DIV: begin
				if (div_done) begin
					if (|quot[41:31]) raw_nxt = neg_r ? -32'sh7FFFFFFF : 32'sh7FFFFFFF;
					else raw_nxt = neg_r ? -$signed({1'b0, quot[30:0]}) : $signed({1'b0, quot[30:0]});
					st_nxt = ESE_SPD_FILT;
				end
			end
			ESE_SPD_FILT: begin
				// shift gain keeps the filter free of a multiplier
				if (tc_c == 15'h0000) filt_nxt = raw_r;
				else filt_nxt = filt_r + 32'(diff >>> fsh);
				vld_nxt = 1'b1;
				st_nxt = ESE_SPD_IDLE;
			end
			default: st_nxt = ESE_SPD_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= ESE_SPD_IDLE;
			neg_r <= 1'b0;
			raw_r <= '0;
			filt_r <= '0;
			vld_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			neg_r <= neg_nxt;
			raw_r <= raw_nxt;
			filt_r <= filt_nxt;
			vld_r <= vld_nxt;
		end
	end

	ese_div #(
		.WN(42),
		.WD(31)
	) u_div (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.start_i(div_start),
		.dividend_i(dvd),
		.divisor_i(dvs),
		.busy_o(),
		.done_o(div_done),
		.quot_o(quot)
	);

	// ----------------------------------------------------------------
	// monitoring values
	// ----------------------------------------------------------------
	logic signed [17:0] fact_c;
	logic [15:0] ratio;
	logic [16:0] nflow;
	logic [13:0] npress;
	logic [31:0] r2;
	logic signed [33:0] sys_r, sys_nxt;
	logic [17:0] flow_r, flow_nxt;
	logic [15:0] press_r, press_nxt;

	// bad-point: flow follows current, pressure its square; no mode input
	always_comb begin
		fact_c = $signed(cfg_i.sys_fact);
		if (fact_c > SYS_FACT_MAX) fact_c = SYS_FACT_MAX;
		if (fact_c < SYS_FACT_MIN) fact_c = SYS_FACT_MIN;
		sys_nxt = 34'($signed(proc_i.act_freq)) * 34'(fact_c);
		if (proc_i.foc) begin
			ratio = proc_i.isq_ratio[15] ? 16'(-$signed(proc_i.isq_ratio)) : proc_i.isq_ratio;
		end else begin
			ratio = proc_i.eff_ratio;
		end
		nflow = (proc_i.nom_flow > FLOW_NOM_MAX) ? FLOW_NOM_MAX : proc_i.nom_flow;
		npress = (proc_i.nom_press > PRESS_NOM_MAX) ? PRESS_NOM_MAX : proc_i.nom_press;
		r2 = 32'(ratio) * 32'(ratio);
		flow_nxt = 18'((33'(nflow) * 33'(ratio)) >> RATIO_FRAC);
		press_nxt = 16'((46'(npress) * 46'(r2)) >> (2 * RATIO_FRAC));
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sys_r <= '0;
			flow_r <= '0;
			press_r <= '0;
		end else begin
			sys_r <= sys_nxt;
			flow_r <= flow_nxt;
			press_r <= press_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign position_o = pos_r;
	assign dir_cw_o = dir_r;
	assign speed_rpm_o = filt_r;
	assign speed_valid_o = vld_r;
	assign ref_fault_o = fpulse_r;
	assign ref_fault_flag_o = fflag_r;
	assign sys_value_o = sys_r;
	assign flow_o = flow_r;
	assign pressure_o = press_r;
endmodule

// >>> include/ese_pkg.sv
// constants, types and carriers for the encoder speed evaluation block
// Contract
// - signed gear numerator, motor turns, default 1.00
// - positive gear denominator 0.01..300.00, never zero
// - speed smoothing filter, 0..32000 us, 0=off
// - single mode counts one edge per mark
// - double mode counts both edges of track
// - quadruple mode counts every A/B state change
// - A rise then B rise means clockwise
// - evaluation multiplies resolution, marks setting unchanged
// - reference spacing checked, mismatch raises fault
// - system value is frequency times signed factor
// - flow and pressure from nominals and current
// - flow and pressure always use bad-point method
// - division marks 1..8192, default 1024
package ese_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned SAMPLE_US = 1000;
	localparam int unsigned SAMPLE_CYC = (CLK_HZ / 1_000_000) * SAMPLE_US;
	localparam int unsigned RPM_K = 60_000_000 / SAMPLE_US; // counts per sample -> per minute

	// ----------------------------------------------------------------
	// setting ranges and reset values
	// ----------------------------------------------------------------
	localparam logic signed [15:0] GEAR_NUM_MAX = 16'sh7530; // 300.00
	localparam logic signed [15:0] GEAR_NUM_MIN = -16'sh7530; // -300.00
	localparam logic signed [15:0] GEAR_NUM_DEF = 16'sh0064; // 1.00
	localparam logic [14:0] GEAR_DEN_MIN = 15'h0001; // 0.01
	localparam logic [14:0] GEAR_DEN_MAX = 15'h7530; // 300.00
	localparam logic [14:0] GEAR_DEN_DEF = 15'h0064; // 1.00
	localparam logic [14:0] FILT_TC_MAX = 15'h7D00; // 32000 us
	localparam logic [13:0] MARKS_MIN = 14'h0001;
	localparam logic [13:0] MARKS_MAX = 14'h2000; // 8192
	localparam logic [13:0] MARKS_DEF = 14'h0400; // 1024
	localparam logic signed [17:0] SYS_FACT_MAX = 18'sh186A0; // 100.000
	localparam logic signed [17:0] SYS_FACT_MIN = -18'sh186A0;
	localparam logic signed [17:0] SYS_FACT_DEF = 18'sh003E8; // 1.000
	localparam logic [16:0] FLOW_NOM_MAX = 17'h1869F; // 99999 m3/h
	localparam logic [13:0] PRESS_NOM_MAX = 14'h270F; // 999.9 kPa in 0.1
	localparam int unsigned RATIO_FRAC = 15; // current ratio 1.0 = 0x8000
	localparam int unsigned FILT_SH_MAX = 6;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ESE_EVAL_SINGLE = 2'b00,
		ESE_EVAL_DOUBLE = 2'b01,
		ESE_EVAL_QUAD = 2'b10
	} ese_eval_e;

	typedef struct packed {
		ese_eval_e eval; // 2'b11 is treated as quadruple
		logic ref_en;
		logic invert;
		logic [13:0] marks;
		logic [15:0] gear_num; // signed, 0.01 units
		logic [14:0] gear_den; // 0.01 units
		logic [14:0] filt_tc; // us
		logic [17:0] sys_fact; // signed, 0.001 units
	} ese_cfg_s;

	typedef struct packed {
		logic [15:0] act_freq; // signed
		logic foc; // 1 = field oriented, 0 = sensorless
		logic [15:0] eff_ratio; // effective current / nominal, Q1.15
		logic [15:0] isq_ratio; // signed, Isq / nominal, Q1.15
		logic [16:0] nom_flow;
		logic [13:0] nom_press;
	} ese_proc_s;

	typedef enum logic [1:0] {
		ESE_SPD_IDLE = 2'b00,
		ESE_SPD_DIV = 2'b01,
		ESE_SPD_FILT = 2'b10
	} ese_spd_e;

endpackage

// >>> tb/ese_enc_model.sv
// quadrature encoder model with one reference pulse per turn
`timescale 1ns/1ns
module ese_enc_model (
	// clock
	input wire logic ref_clk_i,
	// motion request
	input wire logic load_i,
	input wire logic [15:0] steps_i,
	input wire logic cw_i,
	input wire logic [7:0] period_i,
	input wire logic [15:0] rev_i,
	// tracks
	output logic track_a_o,
	output logic track_b_o,
	output logic track_z_o,
	output logic busy_o
);
	logic [15:0] left_r = '0;
	logic [15:0] rpos_r = '0;
	logic [7:0] tmr_r = '0;
	logic [1:0] ph_r = '0;

	// phase 0..3 gives AB 00,10,11,01: A leads B when turning clockwise
	assign track_a_o = ph_r[1] ^ ph_r[0];
	assign track_b_o = ph_r[1];
	assign busy_o = left_r != 16'h0000;

	// step timer; all-ones step count means run without end
	always @(posedge ref_clk_i) begin
		track_z_o <= 1'b0;
		if (load_i) begin
			left_r <= steps_i;
			tmr_r <= period_i;
		end else if (busy_o && tmr_r > 8'h01) begin
			tmr_r <= tmr_r - 8'h01;
		end else if (busy_o) begin
			tmr_r <= period_i;
			ph_r <= cw_i ? ph_r + 2'h1 : ph_r - 2'h1;
			left_r <= (left_r == 16'hFFFF) ? left_r : left_r - 16'h0001;
			rpos_r <= (rpos_r + 16'h0001 >= rev_i) ? 16'h0000 : rpos_r + 16'h0001;
			track_z_o <= rpos_r + 16'h0001 >= rev_i;
		end
	end
endmodule

// >>> tb/ese_top_sva.sv
// port-level assertions for the encoder speed evaluation block
`timescale 1ns/1ns
module ese_top_sva
	import ese_pkg::*;
#(
	parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// watched inputs
	input wire logic track_a_i,
	input wire logic track_b_i,
	input wire ese_cfg_s cfg_i,
	input wire ese_proc_s proc_i,
	input wire logic fault_clr_i,
	// watched outputs
	input wire logic signed [31:0] position_o,
	input wire logic dir_cw_o,
	input wire logic signed [31:0] speed_rpm_o,
	input wire logic speed_valid_o,
	input wire logic ref_fault_o,
	input wire logic ref_fault_flag_o,
	input wire logic signed [33:0] sys_value_o
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	logic signed [17:0] fact_lim;

	// factor held to its legal range; out-of-range settings must saturate
	always_comb begin
		fact_lim = $signed(cfg_i.sys_fact);
		if (fact_lim > SYS_FACT_MAX) fact_lim = SYS_FACT_MAX;
		if (fact_lim < SYS_FACT_MIN) fact_lim = SYS_FACT_MIN;
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	// no track change, no count: catches counting on stale history
	pos_hold_a: assert property ($past(rstn_i) && $stable(track_a_i) && $stable(track_b_i)
		|=> $stable(position_o)) else $error("position moved without track edge");
	pos_step_a: assert property ($past(rstn_i) |-> position_o == $past(position_o)
		|| position_o == $past(position_o) + 1 || position_o == $past(position_o) - 1)
		else $error("position jumped by more than one");
	dir_sign_a: assert property ($past(rstn_i) && !$past(cfg_i.invert)
		&& position_o != $past(position_o) |-> dir_cw_o == (position_o > $past(position_o)))
		else $error("direction disagrees with count");
	ref_off_a: assert property (!cfg_i.ref_en |=> !ref_fault_o)
		else $error("reference fault while check off");
	fault_pulse_a: assert property (ref_fault_o |=> !ref_fault_o)
		else $error("fault pulse too long");
	flag_set_a: assert property (ref_fault_o |-> ref_fault_flag_o)
		else $error("fault flag not set");
	flag_keep_a: assert property (ref_fault_flag_o && !fault_clr_i |=> ref_fault_flag_o)
		else $error("fault flag lost");
	flag_clear_a: assert property (fault_clr_i |=> ref_fault_o || !ref_fault_flag_o)
		else $error("fault flag not cleared");
	sys_value_a: assert property ($past(rstn_i) |-> sys_value_o ==
		$signed($past(proc_i.act_freq)) * $signed($past(fact_lim)))
		else $error("system value wrong");
	speed_hold_a: assert property ($past(rstn_i) && $changed(speed_rpm_o) |-> speed_valid_o)
		else $error("speed changed without valid");
	valid_pulse_a: assert property (speed_valid_o |=> (!speed_valid_o)[*8])
		else $error("speed valid too close");
endmodule

// >>> tb/ese_top_test.sv
// self-checking testbench for the encoder speed evaluation block
`timescale 1ns/1ns
module ese_top_test;
	import ese_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic fault_clr_i = 1'b0;
	logic ld = 1'b0;
	logic cw = 1'b1;
	logic track_a, track_b, track_z, busy, dir_cw, valid, fault, flag;
	logic [15:0] steps = '0;
	logic [15:0] rev = 16'h0008;
	ese_cfg_s cfg = '{ESE_EVAL_QUAD, 1'b0, 1'b0, 14'h0001, 16'h0064, 15'h0064, 15'h0000, 18'h003E8};
	ese_proc_s proc = '0;
	logic signed [31:0] pos, rpm;
	logic signed [33:0] sysv;
	logic [17:0] flow;
	logic [15:0] press;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int fault_pulses = 0;

	// ----------------------------------------------------------------
	// clock, timeout and instances
	// ----------------------------------------------------------------
	always #25 ref_clk_i = ~ref_clk_i;
	// whole run needs about 1300 cycles; a hang stops here
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end
	// one-cycle fault pulses, counted while they stand
	always @(posedge ref_clk_i) begin
		if (fault === 1'b1) fault_pulses++;
	end
	ese_enc_model enc_u (.ref_clk_i(ref_clk_i), .load_i(ld), .steps_i(steps), .cw_i(cw),
		.period_i(8'h02), .rev_i(rev), .track_a_o(track_a), .track_b_o(track_b),
		.track_z_o(track_z), .busy_o(busy));
	ese_top #(.SAMPLE_CYCLES(200)) dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.track_a_i(track_a), .track_b_i(track_b), .track_z_i(track_z), .cfg_i(cfg),
		.proc_i(proc), .fault_clr_i(fault_clr_i), .position_o(pos), .dir_cw_o(dir_cw),
		.speed_rpm_o(rpm), .speed_valid_o(valid), .ref_fault_o(fault),
		.ref_fault_flag_o(flag), .sys_value_o(sysv), .flow_o(flow), .pressure_o(press));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [33:0] seen, input logic [33:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	// inputs always change 5 ns after the rising edge
	task automatic clk(input int n);
		repeat (n) @(posedge ref_clk_i);
		#5;
	endtask
	task automatic move(input logic [15:0] n, input logic d);
		steps = n;
		cw = d;
		ld = 1'b1;
		clk(1);
		ld = 1'b0;
		for (int i = 0; i < 999 && busy; i++) clk(1);
		clk(2);
	endtask
	task automatic wv(input int n);
		repeat (n) begin
			clk(1);
			for (int i = 0; i < 400 && valid !== 1'b1; i++) clk(1);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_count;
		logic signed [31:0] p0;
		ese_eval_e m [3] = '{ESE_EVAL_SINGLE, ESE_EVAL_DOUBLE, ESE_EVAL_QUAD};
		chk("reset position", pos, 0);
		chk("reset dir", dir_cw, 1'b1);
		for (int i = 0; i < 3; i++) begin
			cfg.eval = m[i];
			p0 = pos;
			move(16'h0008, 1'b1);
			chk("cw count", pos, p0 + (32'sd2 << i));
			chk("cw dir", dir_cw, 1'b1);
		end
		p0 = pos;
		move(16'h0008, 1'b0);
		chk("ccw count", pos, p0 - 8);
		chk("ccw dir", dir_cw, 1'b0);
		cfg.invert = 1'b1;
		p0 = pos;
		move(16'h0008, 1'b1);
		chk("inverted count", pos, p0 - 8);
		chk("inverted dir", dir_cw, 1'b0);
		cfg.invert = 1'b0;
		$display("done: edge counting");
	endtask
	// two marks in quadruple mode expect eight counts per turn
	task automatic t_ref;
		cfg.marks = 14'h0002;
		cfg.ref_en = 1'b1;
		move(16'h0014, 1'b1);
		chk("no fault", flag, 1'b0);
		chk("no fault pulse", fault_pulses, 0);
		rev = 16'h0007;
		move(16'h0014, 1'b1);
		chk("fault", flag, 1'b1);
		chk("fault pulses", fault_pulses, 3);
		cfg.ref_en = 1'b0;
		fault_clr_i = 1'b1;
		clk(1);
		fault_clr_i = 1'b0;
		clk(1);
		chk("cleared", flag, 1'b0);
		$display("done: reference track");
	endtask
	task automatic t_mon;
		logic [17:0] ef [2] = '{18'h001F4, 18'h000FA};
		logic [15:0] ep [2] = '{16'h00FA, 16'h003E};
		proc = '{16'hFE0C, 1'b0, 16'h4000, 16'hE000, 17'h003E8, 14'h03E8};
		cfg.sys_fact = 18'h009C4;
		for (int i = 0; i < 2; i++) begin
			proc.foc = i[0];
			clk(2);
			chk("flow", flow, ef[i]);
			chk("pressure", press, ep[i]);
		end
		chk("system value", sysv, -1250000);
		cfg.sys_fact = 18'h278A0;
		clk(2);
		chk("system value min", sysv, 50000000);
		$display("done: monitoring values");
	endtask
	// one count per two cycles over a 200-cycle window, one mark
	task automatic t_speed;
		int exp [4] = '{1500000, 2250000, 2625000, -1500000};
		logic [15:0] gn [4] = '{16'h0064, 16'h0064, 16'h0064, 16'hFF9C};
		logic [14:0] gd [4] = '{15'h0064, 15'h0032, 15'h0032, 15'h0064};
		logic [14:0] tc [4] = '{15'h0000, 15'h07D0, 15'h07D0, 15'h0000};
		cfg.marks = 14'h0001;
		steps = 16'hFFFF;
		ld = 1'b1;
		clk(1);
		ld = 1'b0;
		for (int i = 0; i < 4; i++) begin
			cfg.gear_num = gn[i];
			cfg.gear_den = gd[i];
			cfg.filt_tc = tc[i];
			wv(i == 0 ? 3 : 1);
			chk("speed", rpm, exp[i]);
		end
		$display("done: speed");
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge ref_clk_i);
		#5 rstn_i = 1'b1;
		t_count();
		t_ref();
		t_mon();
		t_speed();
		tally_and_finish();
	end
endmodule

bind ese_top ese_top_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) sva_u (.ref_clk_i(ref_clk_i),
	.rstn_i(rstn_i), .track_a_i(track_a_i), .track_b_i(track_b_i), .cfg_i(cfg_i),
	.proc_i(proc_i), .fault_clr_i(fault_clr_i), .position_o(position_o), .dir_cw_o(dir_cw_o),
	.speed_rpm_o(speed_rpm_o), .speed_valid_o(speed_valid_o), .ref_fault_o(ref_fault_o),
	.ref_fault_flag_o(ref_fault_flag_o), .sys_value_o(sys_value_o));
